// File: dv/count_source_model.sv
/*
 Count pin source: square wave or held level.
 Assumes the bench keeps the half period at two clocks or more.
*/
`timescale 1ns/100ps
module count_source_model
(
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic       hold,
	input  wire logic [3:0] half,
	output logic            pin
);
	logic [3:0] phaseCnt_q;
	initial pin = 1'b0;
	initial phaseCnt_q = 4'h0;
	// Each level lasts half clocks; the bench keeps half at two or more
	always @(posedge clk)
	begin
		if (!run)
		begin
			pin <= hold;
			phaseCnt_q <= 4'h0;
		end
		else if (phaseCnt_q == half - 4'h1)
		begin
			pin <= ~pin;
			phaseCnt_q <= 4'h0;
		end
		else
			phaseCnt_q <= phaseCnt_q + 4'h1;
	end
endmodule // count_source_model

// File: dv/timer0_with_shared_prescaler_bench.sv
/*
 Self-checking bench of the timer core.
 Assumes count_source_model drives the count pin.
*/
`timescale 1ns/100ps
module timer0_with_shared_prescaler_bench
	import timer0_pkg::*;
;
	typedef struct packed
	{
		logic [7:0]  cfg;
		logic        run;
		logic [11:0] span;
		logic [7:0]  delta;
	} row_t;
	logic       clk;
	logic       reset_n;
	reg_wr_t    fileWrite;
	logic [4:0] readAddr;
	logic       configWrite;
	logic       dirWrite;
	logic [7:0] instrOperand;
	logic       wdClr;
	logic       wdTick;
	logic       run;
	logic       hold;
	logic       pin;
	logic [7:0] readData;
	logic [5:0] pinDirection;
	logic [1:0] portWakePullCfg;
	logic       watchdogTimeout;
	phase_t     clockPhase;
	int         errTotal = 0;
	int         samplesChecked = 0;
	row_t       rows [5] = '{'{8'hC8, 1'b0, 12'h010, 8'h04},
		'{8'hE8, 1'b1, 12'h040, 8'h08}, '{8'hF8, 1'b1, 12'h040, 8'h08},
		'{8'hE0, 1'b1, 12'h040, 8'h04}, '{8'hE3, 1'b1, 12'h100, 8'h02}};
	`define CHK(nm, ex, got) \
	begin \
		samplesChecked++; \
		if ((got) !== (ex)) \
		begin \
			errTotal++; \
			$display("unexpected %s exp %h got %h", nm, ex, got); \
		end \
	end
	////////////////////////////////////////////////////////////////////////
	timer0_core #(.PSC_WIDTH(8)) i_timer0_core
	(
		.clk                (clk),
		.reset_n            (reset_n),
		.fileWrite          (fileWrite),
		.readAddr           (readAddr),
		.configWrite        (configWrite),
		.dirWrite           (dirWrite),
		.instrOperand       (instrOperand),
		.watchdogClearInstr (wdClr),
		.watchdogTick       (wdTick),
		.externalCountInput (pin),
		.readData           (readData),
		.pinDirection       (pinDirection),
		.portWakePullCfg    (portWakePullCfg),
		.watchdogTimeout    (watchdogTimeout),
		.clockPhase         (clockPhase)
	);
	count_source_model i_count_source_model
	(
		.clk  (clk),
		.run  (run),
		.hold (hold),
		.half (4'h4),
		.pin  (pin)
	);
	////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		fileWrite = '{a, d, 1'b1};
		cyc(1);
		fileWrite.en = 1'b0;
	endtask
	task op(input logic sel, input logic [7:0] v);
		instrOperand = v;
		configWrite = ~sel;
		dirWrite = sel;
		cyc(1);
		configWrite = 1'b0;
		dirWrite = 1'b0;
	endtask
	task clr();
		wdClr = 1'b1;
		cyc(1);
		wdClr = 1'b0;
	endtask
	// Counts pulses over three samples so either output latency is caught
	task wd(input int n, input logic [7:0] ex);
		logic [7:0] k;
		k = 8'h00;
		repeat (n)
		begin
			wdTick = 1'b1;
			cyc(1);
			wdTick = 1'b0;
			k = k + 8'(watchdogTimeout);
			repeat (2)
			begin
				cyc(1);
				k = k + 8'(watchdogTimeout);
			end
		end
		`CHK("timeouts", ex, k)
		$display("watchdog case done");
	endtask
	// Delta over a whole number of periods is exact whatever the phase
	task meas(input row_t r);
		logic [7:0] a;
		logic [7:0] dv;
		clr();
		op(1'b0, r.cfg);
		run = r.run;
		wr(5'h01, 8'h00);
		cyc(10);
		a = readData;
		cyc(int'(r.span));
		dv = readData - a;
		`CHK("count step", r.delta, dv)
		$display("case %h done", r.cfg);
	endtask
	task summarize();
		$display("checked %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		#200000;
		errTotal++;
		summarize();
	end
	initial
	begin
		reset_n = 1'b0;
		fileWrite = '{5'h00, 8'h00, 1'b0};
		readAddr = 5'h01;
		{configWrite, dirWrite, wdClr, wdTick, run, hold} = 6'h00;
		instrOperand = 8'h00;
		cyc(10);
		reset_n = 1'b1;
		`CHK("reset data", 8'h00, readData)
		`CHK("reset dir", 6'h3F, pinDirection)
		`CHK("reset pull", 2'h3, portWakePullCfg)
		`CHK("reset phase", PH_ONE, clockPhase)
		readAddr = 5'h02;
		cyc(2);
		`CHK("unmapped read", 8'h00, readData)
		`CHK("phase walk", PH_THREE, clockPhase)
		readAddr = 5'h01;
		op(1'b0, 8'h08);
		wr(5'h01, 8'hFD);
		cyc(9);
		`CHK("held count", 8'hFD, readData)
		cyc(12);
		`CHK("wrapped", 8'h00, readData)
		`CHK("pull cfg", 2'h0, portWakePullCfg)
		op(1'b1, 8'h00);
		cyc(1);
		`CHK("pin dir", 6'h00, pinDirection)
		op(1'b0, 8'hE8);
		cyc(1);
		`CHK("pin forced", 6'h04, pinDirection)
		$display("timer and pin tests done");
		fileWrite = '{5'h01, 8'h00, 1'b1};
		cyc(1);
		fileWrite = '{5'h02, 8'h55, 1'b1};
		cyc(1);
		fileWrite.en = 1'b0;
		cyc(12);
		`CHK("no edge", 8'h00, readData)
		hold = 1'b1;
		cyc(2);
		`CHK("early", 8'h00, readData)
		cyc(7);
		`CHK("rising", 8'h01, readData)
		hold = 1'b0;
		cyc(10);
		`CHK("fall ignored", 8'h01, readData)
		op(1'b0, 8'hF8);
		cyc(12);
		wr(5'h01, 8'h00);
		cyc(12);
		hold = 1'b1;
		cyc(10);
		`CHK("rise ignored", 8'h00, readData)
		hold = 1'b0;
		cyc(9);
		`CHK("falling", 8'h01, readData)
		$display("edge tests done");
		foreach (rows[i])
			meas(rows[i]);
		for (int n = 0; n < 8; n++)
			meas('{8'hC0 | 8'(n), 1'b0, 12'h010 << n, 8'h02});
		op(1'b0, 8'hC0);
		wd(3, 8'h03);
		clr();
		wr(5'h01, 8'h00);
		op(1'b0, 8'hCF);
		clr();
		op(1'b0, 8'hCA);
		clr();
		wd(4, 8'h01);
		wd(1, 8'h00);
		clr();
		wd(3, 8'h00);
		summarize();
	end
endmodule // timer0_with_shared_prescaler_bench

// File: hdl/shared_prescaler.sv
/*
 Shared prescaler counter: advances on a one-cycle strobe, clears on demand.
 Assumes the owner logic selects the advance and clear sources.
*/
`timescale 1ns/100ps
module shared_prescaler
#(
	parameter int WIDTH = 8
)
(
	input  logic             clk,
	input  logic             reset_n,
	input  logic             clear,
	input  logic             advance,
	output logic [WIDTH-1:0] count
);

	typedef struct packed
	{
		logic [WIDTH-1:0] count;
	} psc_state_t;

	psc_state_t s_q;
	psc_state_t s_d;

	////////////////////////////////////////////////////////////////////////
	// Clear beats advance so a write never leaves a stale partial count
	always_comb
	begin
		s_d = s_q;
		if (clear)
			s_d.count = '0;
		else if (advance)
			s_d.count = s_q.count + WIDTH'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign count = s_q.count;

endmodule // shared_prescaler

// File: hdl/timer0_core.sv
/*
 Instruction-cycle timer with external count input and shared prescaler.
 Assumes the core drives one-cycle strobes for file writes, the option
 and direction instructions and the watchdog clear, and that the
 external input is already synchronous to clk.
*/
`timescale 1ns/100ps
`include "timer0_defs.svh"
module timer0_core
	import timer0_pkg::*;
#(
	parameter int PSC_WIDTH = 8
)
(
	input  logic                    clk,
	input  logic                    reset_n,
	input  reg_wr_t                 fileWrite,
	input  logic [`FILE_ADDR_W-1:0] readAddr,
	input  logic                    configWrite,
	input  logic                    dirWrite,
	input  logic [7:0]              instrOperand,
	input  logic                    watchdogClearInstr,
	input  logic                    watchdogTick,
	input  logic                    externalCountInput,
	output logic [7:0]              readData,
	output logic [5:0]              pinDirection,
	output logic [1:0]              portWakePullCfg,
	output logic                    watchdogTimeout,
	output phase_t                  clockPhase
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	timer_state_t s_q;
	timer_state_t s_d;

	logic [PSC_WIDTH-1:0] pscCount;
	logic [2:0]           ratio;
	logic                 pscClear;
	logic                 pscAdvance;
	logic                 timerWr;
	logic                 instrTick;
	logic                 sampleEn;
	logic                 lvlRaw;
	logic                 selEdge;
	logic                 syncLvlIn;
	logic                 incFire;
	logic                 ownerWdt;
	logic                 srcExt;
	logic                 timerTap;
	logic                 wdtTap;

	localparam timer_state_t RESET_STATE = '{
		phase:    PH_ONE,
		count:    `COUNT_RESET,
		cfg:      `CONFIG_RESET,
		dir:      `DIR_RESET,
		dirOut:   `DIR_RESET,
		inhibit:  4'h0,
		extPrev:  1'b0,
		syncLvl:  1'b0,
		syncPrev: 1'b0,
		incReq:   1'b0,
		wdtOut:   1'b0,
		rdData:   8'h00
	};

	// Low k bits set; k runs 0..PSC_WIDTH
	function automatic logic [PSC_WIDTH-1:0] tapMask(input logic [3:0] k);
		logic [PSC_WIDTH-1:0] m;
		m = '0;
		for (int i = 0; i < PSC_WIDTH; i++)
			m[i] = (i < int'(k));
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Prescaler ownership and source selection

	assign timerWr = fileWrite.en &&
		fileWrite.addr == `TIMER_COUNT_ADDR;
	assign ownerWdt = s_q.cfg[`OWNER_BIT];
	assign srcExt   = s_q.cfg[`SRC_BIT];
	assign ratio    = s_q.cfg[`RATIO_HI:`RATIO_LO];
	assign instrTick = s_q.phase == PH_FOUR;
	assign sampleEn  = s_q.phase == PH_TWO ||
		s_q.phase == PH_FOUR;

	// Inverting the pin turns a falling edge into a rising one
	assign lvlRaw  = externalCountInput ^ s_q.cfg[`EDGE_BIT];
	assign selEdge = lvlRaw && !s_q.extPrev;

	// Prescaler bit n toggles every 2^n edges, so its level is symmetrical
	assign syncLvlIn = ownerWdt ? lvlRaw : pscCount[ratio];

	assign pscAdvance = ownerWdt ? watchdogTick :
		(srcExt ? selEdge : instrTick);
	assign pscClear = ownerWdt ? watchdogClearInstr : timerWr;

	// Division taps: timer 2^(n+1), watchdog 2^n
	assign timerTap = &(pscCount |
		~tapMask({1'b0, ratio} + 4'h1));
	assign wdtTap = &(pscCount | ~tapMask({1'b0, ratio}));

	// Write wins over a pending increment
	assign incFire = s_q.incReq && s_q.inhibit == 4'h0 &&
		!timerWr;

	shared_prescaler
	#(
		.WIDTH   (PSC_WIDTH)
	)
	u_prescaler
	(
		.clk     (clk),
		.reset_n (reset_n),
		.clear   (pscClear),
		.advance (pscAdvance),
		.count   (pscCount)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		s_d = s_q;

		case (s_q.phase)
			PH_ONE:   s_d.phase = PH_TWO;
			PH_TWO:   s_d.phase = PH_THREE;
			PH_THREE: s_d.phase = PH_FOUR;
			PH_FOUR:  s_d.phase = PH_ONE;
			default:  s_d.phase = PH_ONE;
		endcase

		s_d.extPrev = lvlRaw;
		if (sampleEn)
			s_d.syncLvl = syncLvlIn;
		s_d.syncPrev = s_q.syncLvl;

		if (srcExt)
			s_d.incReq = s_q.syncLvl && !s_q.syncPrev;
		else if (ownerWdt)
			s_d.incReq = instrTick;
		else
			s_d.incReq = instrTick && timerTap;

		if (timerWr)
			s_d.inhibit = 4'(`INHIBIT_CLKS);
		else if (s_q.inhibit != 4'h0)
			s_d.inhibit = s_q.inhibit - 4'h1;

		if (timerWr)
			s_d.count = fileWrite.data;
		else if (incFire)
			s_d.count = s_q.count + 8'h01;

		if (configWrite)
			s_d.cfg = instrOperand;
		if (dirWrite)
			s_d.dir = instrOperand[5:0];

		// Shared pin reads as input while it feeds the counter
		s_d.dirOut = s_d.dir;
		if (s_d.cfg[`SRC_BIT])
			s_d.dirOut[`SHARED_PIN_BIT] = 1'b1;

		s_d.wdtOut = watchdogTick &&
			(ownerWdt ? wdtTap : 1'b1);

		s_d.rdData = (readAddr == `TIMER_COUNT_ADDR) ?
			s_q.count : 8'h00;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			s_q <= RESET_STATE;
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all registered

	assign readData        = s_q.rdData;
	assign pinDirection    = s_q.dirOut;
	assign portWakePullCfg = s_q.cfg[`CFG_TOP_HI:`CFG_TOP_LO];
	assign watchdogTimeout = s_q.wdtOut;
	assign clockPhase      = s_q.phase;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!reset_n);

	sequence sWriteQuiet;
		timerWr ##1 (!timerWr) [*8];
	endsequence

	a_timer_tick_rate: assert property (
		!srcExt && ownerWdt && instrTick && !configWrite
		|=> s_q.incReq ##1 !s_q.incReq [*3])
	else $error("timer mode missed an instruction-cycle increment");

	a_write_inhibit: assert property (
		sWriteQuiet |=> s_q.count == $past(s_q.count, 8))
	else $error("count moved within two cycles after a write");

	a_inhibit_gate: assert property (
		s_q.inhibit != 4'h0 |-> !incFire)
	else $error("increment fired while inhibited");

	a_ext_rise_latency: assert property (
		srcExt && ownerWdt && !configWrite && !s_q.cfg[`EDGE_BIT]
		&& $rose(externalCountInput)
		|-> ##[2:6] s_q.incReq)
	else $error("rising external edge not counted in time");

	a_ext_fall_count: assert property (
		srcExt && ownerWdt && !configWrite && s_q.cfg[`EDGE_BIT]
		&& $fell(externalCountInput)
		|-> ##[2:6] s_q.incReq)
	else $error("falling external edge not counted in time");

	a_wdt_unscaled: assert property (
		!ownerWdt && watchdogTick && !configWrite
		|=> watchdogTimeout)
	else $error("watchdog tick lost while timer owns prescaler");

	a_wdt_postscale: assert property (
		ownerWdt && watchdogTick && !wdtTap |=> !watchdogTimeout)
	else $error("watchdog timeout passed the postscaler early");

	a_timer_ratio: assert property (
		!srcExt && !ownerWdt && !configWrite && instrTick
		&& !timerTap |=> !s_q.incReq)
	else $error("timer increment before prescaler tap");

	a_psc_clear_write: assert property (
		timerWr && !ownerWdt |=> pscCount == '0)
	else $error("count write did not clear prescaler");

	a_psc_clear_wdt: assert property (
		watchdogClearInstr && ownerWdt |=> pscCount == '0)
	else $error("watchdog clear did not clear prescaler");

	a_psc_reset: assert property (
		$rose(reset_n) |-> pscCount == '0)
	else $error("prescaler not zero after reset");

	a_sync_phase: assert property (
		$changed(s_q.syncLvl) |-> $past(sampleEn))
	else $error("sampler changed outside phases two and four");

	a_ext_pin_input: assert property (
		s_q.cfg[`SRC_BIT] |-> pinDirection[`SHARED_PIN_BIT])
	else $error("shared pin driven while counting it");

	a_read_count: assert property (
		readAddr == `TIMER_COUNT_ADDR && !timerWr
		|=> readData == $past(s_q.count))
	else $error("count read returned wrong value");

	a_count_wrap: assert property (
		incFire && s_q.count == 8'hFF |=> s_q.count == 8'h00)
	else $error("count did not wrap to zero");

	////////////////////////////////////////////////////////////////////////
	// Register, phase and prescaler bookkeeping

	a_phase_walk: assert property (
		s_q.phase == PH_ONE |=> s_q.phase == PH_TWO
		##1 s_q.phase == PH_THREE ##1 s_q.phase == PH_FOUR
		##1 s_q.phase == PH_ONE)
	else $error("phase sequence broken");

	a_phase_onehot: assert property (
		$onehot(s_q.phase))
	else $error("phase not one-hot");

	a_inhibit_load: assert property (
		timerWr |=> s_q.inhibit == 4'(`INHIBIT_CLKS))
	else $error("write did not start the inhibit window");

	a_count_load: assert property (
		timerWr |=> s_q.count == $past(fileWrite.data))
	else $error("count write did not land");

	a_count_step: assert property (
		incFire
		|=> s_q.count == $past(s_q.count) + 8'h01)
	else $error("increment did not add one");

	a_count_hold: assert property (
		!timerWr && !incFire |=> $stable(s_q.count))
	else $error("count moved without write or increment");

	a_unmapped_write: assert property (
		fileWrite.en && fileWrite.addr != `TIMER_COUNT_ADDR
		&& !incFire |=> $stable(s_q.count))
	else $error("write to another address moved the count");

	a_read_unmapped: assert property (
		readAddr != `TIMER_COUNT_ADDR |=> readData == 8'h00)
	else $error("unmapped read returned nonzero data");

	a_dir_follow: assert property (
		!s_q.cfg[`SRC_BIT] |-> pinDirection == s_q.dir)
	else $error("pin direction differs from direction register");

	a_dir_load: assert property (
		dirWrite |=> s_q.dir == $past(instrOperand[5:0]))
	else $error("direction write did not land");

	a_psc_idle_wdt: assert property (
		ownerWdt && !watchdogTick && !watchdogClearInstr
		|=> $stable(pscCount))
	else $error("watchdog prescaler moved without a tick");

	a_psc_idle_timer: assert property (
		!ownerWdt && !srcExt && !timerWr && !instrTick
		|=> $stable(pscCount))
	else $error("timer prescaler moved off instruction tick");

	a_timer_prescaled: assert property (
		!srcExt && !ownerWdt && !configWrite && instrTick
		&& timerTap |=> s_q.incReq)
	else $error("timer missed increment at prescaler tap");

	a_ext_idle: assert property (
		srcExt && !(s_q.syncLvl && !s_q.syncPrev) |=> !s_q.incReq)
	else $error("external mode counted without a sampled edge");

	c_wrap: cover property (incFire && s_q.count == 8'hFF);
	c_ext_scaled: cover property (srcExt && !ownerWdt && incFire);
	c_wdt_scaled: cover property (
		ownerWdt && ratio != 3'h0 && watchdogTimeout);
	c_write_quiet: cover property (sWriteQuiet);
	c_ext_falling: cover property (
		srcExt && s_q.cfg[`EDGE_BIT] && incFire);

endmodule // timer0_core

// File: hdl/timer0_defs.svh
/*
 Constants of the instruction-cycle timer with its shared prescaler.
 Assumes one clock at the oscillator rate: one clock period is one Tosc.
*/
// Overview of operation
// - Source bit clear: count instruction cycles, or prescaler ticks when prescaler assigned.
// - A count register write blocks increments for the next two instruction cycles.
// - Source bit set: count edges of the external count input.
// - Edge bit clear counts rising edges; set counts falling edges.
// - Prescaler serves timer or watchdog only; owner bit one gives it to watchdog.
// - Owner bit and three ratio bits set owner and ratio, 1:2 to 1:256 for timer, 1:1 to 1:128 for watchdog.
// - Watchdog-owned prescaler: timer unscaled, prescaler postscales watchdog output.
// - Timer-owned prescaler is cleared by every count register write.
// - Watchdog-owned prescaler is cleared by the watchdog clear instruction.
// - Prescaler has no software access; every reset clears it.
// - External input is divided into a symmetrical prescaler output; none means raw.
// - Prescaler output is sampled in phases two and four before counting.
// - External change to counter increment takes three to seven Tosc.
// - External source forces the shared pin to input regardless of direction bit.
// - Count register is 8 bits, read and written at data address 01h.
////////////////////////////////////////////////////////////////////////////////
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

`define FILE_ADDR_W       5
`define TIMER_COUNT_ADDR  5'h01
`define CONFIG_RESET      8'hFF
`define DIR_RESET         6'h3F
`define COUNT_RESET       8'h00
`define SRC_BIT           5
`define EDGE_BIT          4
`define OWNER_BIT         3
`define RATIO_HI          2
`define RATIO_LO          0
`define CFG_TOP_HI        7
`define CFG_TOP_LO        6
`define SHARED_PIN_BIT    2
`define TOSC_NS           8
`define TOSC_PER_INSTR    4
`define INHIBIT_INSTR     2
`define INHIBIT_CLKS      (`INHIBIT_INSTR * `TOSC_PER_INSTR)
`define INC_LAT_MIN_TOSC  3
`define INC_LAT_MAX_TOSC  7

`endif

// File: hdl/timer0_pkg.sv
/*
 Types of the instruction-cycle timer.
 Assumes timer0_defs.svh is read first by every user.
*/
package timer0_pkg;

	typedef enum logic [3:0]
	{
		PH_ONE   = 4'h1,
		PH_TWO   = 4'h2,
		PH_THREE = 4'h4,
		PH_FOUR  = 4'h8
	} phase_t;

	typedef struct packed
	{
		logic [4:0] addr;
		logic [7:0] data;
		logic       en;
	} reg_wr_t;

	typedef struct packed
	{
		phase_t     phase;
		logic [7:0] count;
		logic [7:0] cfg;
		logic [5:0] dir;
		logic [5:0] dirOut;
		logic [3:0] inhibit;
		logic       extPrev;
		logic       syncLvl;
		logic       syncPrev;
		logic       incReq;
		logic       wdtOut;
		logic [7:0] rdData;
	} timer_state_t;

endpackage
